// >>> logic/nbp_host.sv
// host controller issuing bypass, program and buffered program sequences to a nor flash
`timescale 1ns/1ns
module nbp_host
  import nbp_pkg::*;
#(
  parameter int BUF_WORDS = NBP_BUF_WORDS
)(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              cmd_valid,
  input  wire nbp_cmd_t          cmd,
  input  wire logic [NBP_AW-1:0] cmd_addr,
  input  wire logic [NBP_DW-1:0] cmd_data,
  input  wire logic [5:0]        cmd_count,
  input  wire logic              vpp_high,
  input  wire logic              load_valid,
  input  wire logic [NBP_AW-1:0] load_addr,
  input  wire logic [NBP_DW-1:0] load_data,
  input  wire logic [NBP_DW-1:0] dq_in,
  output logic                   cmd_ready,
  output logic                   load_ready,
  output logic                   busy,
  output logic                   op_done,
  output logic                   op_fail,
  output logic                   op_abort,
  output logic                   op_refused,
  output logic                   bypass_mode,
  output logic [NBP_AW-1:0]      flash_addr,
  output logic [NBP_DW-1:0]      dq_out,
  output logic                   dq_oe,
  output logic                   ce_b,
  output logic                   oe_b,
  output logic                   we_b
);
  typedef enum logic [2:0] {NBP_H_IDLE, NBP_H_WRITE, NBP_H_LOAD, NBP_H_POLL1,
                            NBP_H_POLL2} nbp_hst_t;
  nbp_hst_t          st, next_st;
  nbp_cmd_t          cur, next_cur;
  logic [2:0]        step, next_step;
  logic [5:0]        left, next_left;
  logic              byp, next_byp;
  logic              cstart, next_cstart;
  logic              cwr, next_cwr;
  logic              rchk, next_rchk;
  logic [NBP_AW-1:0] caddr, next_caddr, base, next_base;
  logic [NBP_DW-1:0] cdata, next_cdata, tgt, next_tgt, prev, next_prev;
  logic              next_cmd_ready, next_load_ready, next_busy, next_op_done;
  logic              next_op_fail, next_op_abort, next_op_refused;
  logic              cdone;
  logic [NBP_DW-1:0] crdata;

  function automatic logic [NBP_AW-1:0] unl(input logic [15:0] a);
    return {{(NBP_AW-16){1'b0}}, a};
  endfunction
  function automatic logic same_page(input logic [NBP_AW-1:0] a, input logic [NBP_AW-1:0] b);
    return a[NBP_AW-1:NBP_PAGE_BITS] == b[NBP_AW-1:NBP_PAGE_BITS];
  endfunction

  nbp_bus_cycle u_cycle (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .start      (cstart),
    .is_write   (cwr),
    .addr       (caddr),
    .wdata      (cdata),
    .dq_in      (dq_in),
    .done       (cdone),
    .rdata      (crdata),
    .flash_addr (flash_addr),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .ce_b       (ce_b),
    .oe_b       (oe_b),
    .we_b       (we_b)
  );

  always_comb begin
    logic       eff_byp;
    logic       more;
    logic       aborted;
    eff_byp = byp | vpp_high;
    more = 1'b0;
    aborted = crdata[NBP_ABORT_BIT] && crdata[NBP_POLL_BIT] != tgt[NBP_POLL_BIT];
    next_st = st;
    next_cur = cur;
    next_step = step;
    next_left = left;
    next_byp = byp;
    next_cstart = 1'b0;
    next_cwr = cwr;
    next_rchk = rchk;
    next_caddr = caddr;
    next_cdata = cdata;
    next_base = base;
    next_tgt = tgt;
    next_prev = prev;
    next_cmd_ready = 1'b0;
    next_load_ready = 1'b0;
    next_busy = busy;
    next_op_done = 1'b0;
    next_op_fail = 1'b0;
    next_op_abort = 1'b0;
    next_op_refused = 1'b0;
    case (st)
      NBP_H_IDLE: begin
        next_cmd_ready = 1'b1;
        if (cmd_valid && cmd_ready) begin
          next_cmd_ready = 1'b0;
          // bypass allows only its own command set; the rest is refused here
          if ((eff_byp && (cmd == NBP_C_BYPASS_ON || cmd == NBP_C_SUSPEND ||
                           cmd == NBP_C_RESUME)) ||
              (!eff_byp && cmd == NBP_C_BYPASS_OFF) ||
              (cmd == NBP_C_BUFFER && 7'(cmd_count) + 7'h01 > 7'(BUF_WORDS))) begin
            next_op_refused = 1'b1;
          end else begin
            next_st = NBP_H_WRITE;
            next_cur = cmd;
            next_busy = 1'b1;
            next_base = cmd_addr;
            next_tgt = cmd_data;
            next_left = cmd_count;
            // skip the two unlock writes in bypass mode, except for abort reset
            next_step = (eff_byp && cmd != NBP_C_ABORT_RESET) ? 3'h2 : 3'h0;
            if (cmd == NBP_C_RESET || cmd == NBP_C_SUSPEND || cmd == NBP_C_RESUME)
              next_step = 3'h2;
            next_cstart = 1'b1;
            next_cwr = 1'b1;
          end
        end
      end
      NBP_H_WRITE: if (cdone) begin
        next_step = step + 3'h1;
        next_cstart = 1'b1;
        next_cwr = 1'b1;
        more = 1'b1;
        case (cur)
          NBP_C_BYPASS_ON:   more = step < 3'h2;
          NBP_C_BYPASS_OFF:  more = step < 3'h3;
          NBP_C_PROGRAM:     more = step < 3'h3;
          NBP_C_BUFFER:      more = step < 3'h3 || step == 3'h4;
          NBP_C_ABORT_RESET: more = step < 3'h2;
          default:           more = 1'b0;
        endcase
        if (!more) begin
          next_cstart = 1'b0;
          case (cur)
            NBP_C_BYPASS_ON:  next_byp = 1'b1;
            NBP_C_BYPASS_OFF: next_byp = 1'b0;
            default: ;
          endcase
          if (cur == NBP_C_BUFFER && step != 3'h5) begin
            next_st = NBP_H_LOAD;
            next_step = 3'h0;
            next_load_ready = 1'b1;
          end else if (cur == NBP_C_PROGRAM || cur == NBP_C_BUFFER) begin
            next_st = NBP_H_POLL1;
            next_rchk = 1'b0;
            next_cstart = 1'b1;
            next_cwr = 1'b0;
            next_caddr = base;
          end else begin
            next_st = NBP_H_IDLE;
            next_busy = 1'b0;
            next_op_done = 1'b1;
          end
        end
      end
      NBP_H_LOAD: begin
        // ready only once the previous load write has left the bus
        next_load_ready = load_ready | cdone;
        if (load_valid && load_ready) begin
          // page crossing is refused host-side instead of provoking an abort
          if (!same_page(load_addr, caddr) && step != 3'h0) begin
            next_op_refused = 1'b1;
          end else begin
            next_load_ready = 1'b0;
            next_cstart = 1'b1;
            next_cwr = 1'b1;
            next_caddr = load_addr;
            next_cdata = load_data;
            next_tgt = load_data;
            next_base = load_addr;
            next_step = 3'h1;
            if (left == 6'h00) next_st = NBP_H_WRITE;
            else next_left = left - 6'h01;
            if (left == 6'h00) next_step = 3'h4;
          end
        end
      end
      NBP_H_POLL1: if (cdone) begin
        next_prev = crdata;
        next_cstart = 1'b1;
        next_st = NBP_H_POLL2;
      end
      NBP_H_POLL2: if (cdone) begin
        next_cstart = 1'b1;
        next_prev = crdata;
        if (crdata[NBP_TOGGLE_BIT] == prev[NBP_TOGGLE_BIT]) begin
          // toggle stopped: finished, or a protected target ignored quietly
          next_cstart = 1'b0;
          next_st = NBP_H_IDLE;
          next_busy = 1'b0;
          next_op_done = 1'b1;
        end else if ((aborted || crdata[NBP_FAIL_BIT]) && !rchk) begin
          // last status then first array word can mimic a fault: poll a fresh pair
          next_rchk = 1'b1;
          next_st = NBP_H_POLL1;
        end else if (aborted || crdata[NBP_FAIL_BIT]) begin
          next_cstart = 1'b0;
          next_st = NBP_H_IDLE;
          next_busy = 1'b0;
          next_op_abort = aborted;
          next_op_fail = ~aborted;
        end
      end
      default: next_st = NBP_H_IDLE;
    endcase
    // command word selection for the write steps
    if (st != NBP_H_LOAD && st != NBP_H_POLL1 && st != NBP_H_POLL2 && next_cstart &&
        next_cwr) begin
      case (next_step)
        3'h0: begin next_caddr = unl(NBP_UNLOCK1_ADDR); next_cdata = NBP_UNLOCK1_DATA; end
        3'h1: begin next_caddr = unl(NBP_UNLOCK2_ADDR); next_cdata = NBP_UNLOCK2_DATA; end
        3'h2: begin
          next_caddr = (next_cur == NBP_C_BUFFER || next_cur == NBP_C_SUSPEND ||
                        next_cur == NBP_C_RESUME) ? next_base : unl(NBP_UNLOCK1_ADDR);
          case (next_cur)
            NBP_C_BYPASS_ON:  next_cdata = NBP_CMD_BYPASS;
            NBP_C_BYPASS_OFF: next_cdata = NBP_CMD_BYP_RST1;
            NBP_C_PROGRAM:    next_cdata = NBP_CMD_PROGRAM;
            NBP_C_BUFFER:     next_cdata = NBP_CMD_WRBUF;
            NBP_C_SUSPEND:    next_cdata = NBP_CMD_SUSPEND;
            NBP_C_RESUME:     next_cdata = NBP_CMD_RESUME;
            default:          next_cdata = NBP_CMD_RESET;
          endcase
        end
        3'h3: begin
          next_caddr = next_base;
          next_cdata = (next_cur == NBP_C_BUFFER) ? NBP_DW'(next_left) :
                       (next_cur == NBP_C_BYPASS_OFF) ? NBP_CMD_BYP_RST2 : next_tgt;
        end
        default: begin next_caddr = next_base; next_cdata = NBP_CMD_CONFIRM; end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= NBP_H_IDLE;
      cur <= NBP_C_RESET;
      step <= 3'h0;
      left <= 6'h00;
      byp <= 1'b0;
      cstart <= 1'b0;
      cwr <= 1'b0;
      rchk <= 1'b0;
      caddr <= '0;
      cdata <= '0;
      base <= '0;
      tgt <= '0;
      prev <= '0;
      cmd_ready <= 1'b0;
      load_ready <= 1'b0;
      busy <= 1'b0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
      op_abort <= 1'b0;
      op_refused <= 1'b0;
      bypass_mode <= 1'b0;
    end else begin
      st <= next_st;
      cur <= next_cur;
      step <= next_step;
      left <= next_left;
      byp <= next_byp;
      cstart <= next_cstart;
      cwr <= next_cwr;
      rchk <= next_rchk;
      caddr <= next_caddr;
      cdata <= next_cdata;
      base <= next_base;
      tgt <= next_tgt;
      prev <= next_prev;
      cmd_ready <= next_cmd_ready;
      load_ready <= next_load_ready;
      busy <= next_busy;
      op_done <= next_op_done;
      op_fail <= next_op_fail;
      op_abort <= next_op_abort;
      op_refused <= next_op_refused;
      bypass_mode <= next_byp | vpp_high;
    end
  end
endmodule // nbp_host

// >>> logic/nbp_pkg.sv
// package: command codes, bus timing and sequence constants for the flash host controller
package nbp_pkg;
  localparam int          NBP_AW           = 23;
  localparam int          NBP_DW           = 16;
  localparam int          NBP_BUF_WORDS    = 32;
  localparam int          NBP_PAGE_BITS    = 5;
  localparam int          NBP_BLK_BITS     = 16;
  localparam logic [15:0] NBP_UNLOCK1_ADDR = 16'h0555;
  localparam logic [15:0] NBP_UNLOCK2_ADDR = 16'h02aa;
  localparam logic [15:0] NBP_UNLOCK1_DATA = 16'h00aa;
  localparam logic [15:0] NBP_UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] NBP_CMD_BYPASS   = 16'h0020;
  localparam logic [15:0] NBP_CMD_BYP_RST1 = 16'h0090;
  localparam logic [15:0] NBP_CMD_BYP_RST2 = 16'h0000;
  localparam logic [15:0] NBP_CMD_PROGRAM  = 16'h00a0;
  localparam logic [15:0] NBP_CMD_WRBUF    = 16'h0025;
  localparam logic [15:0] NBP_CMD_CONFIRM  = 16'h0029;
  localparam logic [15:0] NBP_CMD_RESET    = 16'h00f0;
  localparam logic [15:0] NBP_CMD_SUSPEND  = 16'h00b0;
  localparam logic [15:0] NBP_CMD_RESUME   = 16'h0030;
  localparam int          NBP_POLL_BIT     = 7;
  localparam int          NBP_TOGGLE_BIT   = 6;
  localparam int          NBP_FAIL_BIT     = 5;
  localparam int          NBP_ABORT_BIT    = 1;
  // strobe timing: printed in ns, converted at 4 ns per mclk
  localparam int          NBP_CLK_NS       = 4;
  localparam int          NBP_T_SETUP_NS   = 20;
  localparam int          NBP_T_PULSE_NS   = 40;
  localparam int          NBP_T_READ_NS    = 80;
  localparam logic [5:0]  NBP_SETUP_CYC    = 6'((NBP_T_SETUP_NS + NBP_CLK_NS - 1) / NBP_CLK_NS);
  localparam logic [5:0]  NBP_PULSE_CYC    = 6'((NBP_T_PULSE_NS + NBP_CLK_NS - 1) / NBP_CLK_NS);
  localparam logic [5:0]  NBP_READ_CYC     = 6'((NBP_T_READ_NS + NBP_CLK_NS - 1) / NBP_CLK_NS);
  typedef enum logic [1:0] {NBP_OP_IDLE, NBP_OP_WRITE, NBP_OP_READ} nbp_op_t;
  typedef enum logic [3:0] {
    NBP_C_BYPASS_ON, NBP_C_BYPASS_OFF, NBP_C_PROGRAM, NBP_C_BUFFER,
    NBP_C_RESET, NBP_C_ABORT_RESET, NBP_C_SUSPEND, NBP_C_RESUME
  } nbp_cmd_t;
endpackage

// >>> logic/nbp_bus_cycle.sv
// one asynchronous flash bus cycle: write or read with strobe timing
`timescale 1ns/1ns
module nbp_bus_cycle
  import nbp_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              start,
  input  wire logic              is_write,
  input  wire logic [NBP_AW-1:0] addr,
  input  wire logic [NBP_DW-1:0] wdata,
  input  wire logic [NBP_DW-1:0] dq_in,
  output logic                   done,
  output logic [NBP_DW-1:0]      rdata,
  output logic [NBP_AW-1:0]      flash_addr,
  output logic [NBP_DW-1:0]      dq_out,
  output logic                   dq_oe,
  output logic                   ce_b,
  output logic                   oe_b,
  output logic                   we_b
);
  typedef enum logic [1:0] {NBP_B_IDLE, NBP_B_SETUP, NBP_B_PULSE, NBP_B_HOLD} nbp_bst_t;
  nbp_bst_t          st, next_st;
  logic [5:0]        cnt, next_cnt;
  logic              wr, next_wr;
  logic              next_done, next_ce_b, next_oe_b, next_we_b, next_dq_oe;
  logic [NBP_AW-1:0] next_flash_addr;
  logic [NBP_DW-1:0] next_dq_out, next_rdata;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_wr = wr;
    next_done = 1'b0;
    next_ce_b = ce_b;
    next_oe_b = oe_b;
    next_we_b = we_b;
    next_dq_oe = dq_oe;
    next_flash_addr = flash_addr;
    next_dq_out = dq_out;
    next_rdata = rdata;
    case (st)
      NBP_B_IDLE: if (start) begin
        next_st = NBP_B_SETUP;
        next_wr = is_write;
        next_flash_addr = addr;
        next_dq_out = wdata;
        next_dq_oe = is_write;
        next_ce_b = 1'b0;
        next_cnt = NBP_SETUP_CYC;
      end
      NBP_B_SETUP: if (cnt <= 6'h01) begin
        next_st = NBP_B_PULSE;
        next_we_b = ~wr;
        next_oe_b = wr;
        next_cnt = wr ? NBP_PULSE_CYC : NBP_READ_CYC;
      end else next_cnt = cnt - 6'h01;
      NBP_B_PULSE: if (cnt <= 6'h01) begin
        next_st = NBP_B_HOLD;
        next_we_b = 1'b1;
        next_oe_b = 1'b1;
        if (!wr) next_rdata = dq_in;
        next_cnt = NBP_SETUP_CYC;
      end else next_cnt = cnt - 6'h01;
      NBP_B_HOLD: if (cnt <= 6'h01) begin
        // data held past we rise so the latch edge sees stable data
        next_st = NBP_B_IDLE;
        next_ce_b = 1'b1;
        next_dq_oe = 1'b0;
        next_done = 1'b1;
      end else next_cnt = cnt - 6'h01;
      default: next_st = NBP_B_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st <= NBP_B_IDLE;
      cnt <= 6'h00;
      wr <= 1'b0;
      done <= 1'b0;
      ce_b <= 1'b1;
      oe_b <= 1'b1;
      we_b <= 1'b1;
      dq_oe <= 1'b0;
      flash_addr <= '0;
      dq_out <= '0;
      rdata <= '0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      wr <= next_wr;
      done <= next_done;
      ce_b <= next_ce_b;
      oe_b <= next_oe_b;
      we_b <= next_we_b;
      dq_oe <= next_dq_oe;
      flash_addr <= next_flash_addr;
      dq_out <= next_dq_out;
      rdata <= next_rdata;
    end
  end
endmodule // nbp_bus_cycle

// >>> tb/nbp_host_assertions.sv
// assertions on the port behaviour of the flash host controller
`timescale 1ns/1ns
module nbp_host_chk
  import nbp_pkg::*;
#(
  parameter int BUF_WORDS = NBP_BUF_WORDS
)(
  input wire logic              mclk,
  input wire logic              rst_b,
  input wire logic              cmd_valid,
  input wire nbp_cmd_t          cmd,
  input wire logic [5:0]        cmd_count,
  input wire logic              vpp_high,
  input wire logic              cmd_ready,
  input wire logic              op_done,
  input wire logic              op_fail,
  input wire logic              op_abort,
  input wire logic              op_refused,
  input wire logic              bypass_mode,
  input wire logic [NBP_AW-1:0] flash_addr,
  input wire logic [NBP_DW-1:0] dq_out,
  input wire logic              dq_oe,
  input wire logic              ce_b,
  input wire logic              oe_b,
  input wire logic              we_b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic take;
  assign take = cmd_valid && cmd_ready;
  we_needs_ce_a: assert property (!we_b |-> !ce_b && dq_oe && oe_b)
    else $error("write strobe without select or drive");
  rd_release_a: assert property (!oe_b |-> !ce_b && !dq_oe)
    else $error("read strobe while driving the bus");
  we_width_a: assert property ($fell(we_b) |=> !we_b [*8])
    else $error("write strobe pulse too short");
  wr_hold_a: assert property (!we_b && !$fell(we_b) |-> $stable(flash_addr) && $stable(dq_out))
    else $error("address or data moved under the write strobe");
  one_result_a: assert property ($onehot0({op_done, op_fail, op_abort, op_refused}))
    else $error("two outcomes at once");
  done_pulse_a: assert property (op_done |=> !op_done)
    else $error("done pulse longer than one cycle");
  big_count_a: assert property (take && cmd == NBP_C_BUFFER && int'(cmd_count) + 1 > BUF_WORDS
    |=> op_refused)
    else $error("oversized buffer count not refused");
  byp_refuse_a: assert property (take && (bypass_mode ? cmd == NBP_C_BYPASS_ON
    : cmd == NBP_C_BYPASS_OFF) |=> op_refused)
    else $error("bypass command in wrong mode not refused");
  vpp_byp_a: assert property (vpp_high |=> bypass_mode)
    else $error("high voltage without bypass mode");
  cover property (op_done);
  cover property (op_fail);
  cover property (op_abort);
  cover property (op_refused);
endmodule // nbp_host_chk
bind nbp_host nbp_host_chk #(.BUF_WORDS(BUF_WORDS)) chk (
  .mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_count(cmd_count),
  .vpp_high(vpp_high), .cmd_ready(cmd_ready), .op_done(op_done), .op_fail(op_fail),
  .op_abort(op_abort), .op_refused(op_refused), .bypass_mode(bypass_mode),
  .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .ce_b(ce_b), .oe_b(oe_b),
  .we_b(we_b));

// >>> tb/nbp_flash_model.sv
// flash device model: logs host writes and answers polling reads
`timescale 1ns/1ns
module nbp_flash_model
  import nbp_pkg::*;
(
  input  wire logic              ce_b,
  input  wire logic              oe_b,
  input  wire logic              we_b,
  input  wire logic [NBP_AW-1:0] flash_addr,
  input  wire logic [NBP_DW-1:0] dq_out,
  input  wire logic [1:0]        fault_mode,
  output logic [NBP_DW-1:0]      dq_in
);
  localparam int RUN_RDS = 5;
  logic [NBP_AW-1:0] wa[$];
  logic [NBP_DW-1:0] wd[$];
  logic [NBP_DW-1:0] arr, last_d, rdv, prev;
  logic [1:0]        fault;
  logic              byp, pend, tog;
  int                run;
  initial begin
    {arr, last_d, rdv, prev} = '1;
    fault = 2'h0;
    byp = 1'b0;
    pend = 1'b0;
    tog = 1'b0;
    run = 0;
  end
  // codes are decoded without address checks; bench data avoids code values
  always @(posedge we_b) if (!ce_b) begin
    wa.push_back(flash_addr);
    wd.push_back(dq_out);
    if (pend) begin
      pend = 1'b0;
      last_d = dq_out;
      arr = arr & dq_out;
      run = RUN_RDS;
      fault = fault_mode;
    end else if (dq_out == NBP_CMD_PROGRAM) pend = 1'b1;
    else if (dq_out == NBP_CMD_CONFIRM) begin
      last_d = prev;
      run = RUN_RDS;
      fault = fault_mode;
    end else if (dq_out == NBP_CMD_BYPASS) byp = 1'b1;
    else if (dq_out == NBP_CMD_BYP_RST2 && prev == NBP_CMD_BYP_RST1) byp = 1'b0;
    else if (dq_out == NBP_CMD_RESET) fault = 2'h0;
    prev = dq_out;
  end
  always @(negedge oe_b) begin
    if (run > 0 || fault != 2'h0) begin
      tog = ~tog;
      rdv = '0;
      rdv[NBP_POLL_BIT] = ~last_d[NBP_POLL_BIT];
      rdv[NBP_TOGGLE_BIT] = tog;
      rdv[NBP_FAIL_BIT] = fault == 2'h1;
      rdv[NBP_ABORT_BIT] = fault == 2'h2;
      if (run > 0) run--;
    end else rdv = arr;
  end
  // released bus shows the inverse so a stale value never passes
  assign dq_in = oe_b ? ~rdv : rdv;
endmodule // nbp_flash_model

// >>> tb/tb_top.sv
// testbench for the flash host controller against the device model
`timescale 1ns/1ns
module tb_top;
  import nbp_pkg::*;
  localparam logic [NBP_AW-1:0] U1 = 23'(NBP_UNLOCK1_ADDR);
  localparam logic [NBP_AW-1:0] U2 = 23'(NBP_UNLOCK2_ADDR);
  logic              mclk, rst_b, cmd_valid, vpp_high, load_valid;
  nbp_cmd_t          cmd;
  logic [NBP_AW-1:0] cmd_addr, load_addr, flash_addr;
  logic [NBP_DW-1:0] cmd_data, load_data, dq_in, dq_out;
  logic [5:0]        cmd_count;
  logic [1:0]        fault_mode;
  logic              cmd_ready, load_ready, busy, op_done, op_fail, op_abort, op_refused;
  logic              bypass_mode, dq_oe, ce_b, oe_b, we_b;
  logic [3:0]        ev;
  int                bad_count, cmp_count;
  nbp_host uut (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_count(cmd_count), .vpp_high(vpp_high),
    .load_valid(load_valid), .load_addr(load_addr), .load_data(load_data), .dq_in(dq_in),
    .cmd_ready(cmd_ready), .load_ready(load_ready), .busy(busy), .op_done(op_done),
    .op_fail(op_fail), .op_abort(op_abort), .op_refused(op_refused),
    .bypass_mode(bypass_mode), .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
    .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b));
  nbp_flash_model flash (.ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .flash_addr(flash_addr),
    .dq_out(dq_out), .fault_mode(fault_mode), .dq_in(dq_in));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic w(input int k, input logic [NBP_AW-1:0] a, input logic [NBP_DW-1:0] d);
    chk({flash.wa[k], flash.wd[k]}, {1'b0, a, d});
  endtask
  task automatic unl(input int k);
    w(k, U1, NBP_UNLOCK1_DATA);
    w(k + 1, U2, NBP_UNLOCK2_DATA);
  endtask
  task automatic issue(input nbp_cmd_t c, input logic [NBP_AW-1:0] a,
                       input logic [NBP_DW-1:0] d, input logic [5:0] n);
    int i;
    flash.wa.delete();
    flash.wd.delete();
    cmd_valid <= 1'b1;
    cmd <= c;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_count <= n;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (cmd_ready !== 1'b1 && i < 300);
    cmd_valid <= 1'b0;
  endtask
  task automatic ld(input logic [NBP_AW-1:0] a, input logic [NBP_DW-1:0] d);
    int i;
    // an edge between loads keeps valid from falling and rising in one step
    @(posedge mclk);
    load_valid <= 1'b1;
    load_addr <= a;
    load_data <= d;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (load_ready !== 1'b1 && i < 300);
    load_valid <= 1'b0;
  endtask
  // outcome as {done, fail, abort, refused}
  task automatic wait_ev();
    int i;
    ev = 4'h0;
    for (i = 0; i < 4000 && ev === 4'h0; i++) begin
      @(posedge mclk);
      ev = {op_done, op_fail, op_abort, op_refused};
    end
  endtask
  task automatic t_program();
    issue(NBP_C_PROGRAM, 23'h001234, 16'h5a3c, 6'h00);
    @(posedge mclk);
    chk(busy, 1'b1);
    wait_ev();
    chk(ev, 4'h8);
    chk(busy, 1'b0);
    chk(flash.wa.size(), 4);
    unl(0);
    w(2, U1, NBP_CMD_PROGRAM);
    w(3, 23'h001234, 16'h5a3c);
    issue(NBP_C_BYPASS_OFF, '0, '0, '0);
    wait_ev();
    chk(ev, 4'h1);
  endtask
  task automatic t_bypass();
    issue(NBP_C_BYPASS_ON, '0, '0, '0);
    wait_ev();
    chk(flash.wa.size(), 3);
    unl(0);
    w(2, U1, NBP_CMD_BYPASS);
    chk(bypass_mode, 1'b1);
    issue(NBP_C_BYPASS_ON, '0, '0, '0);
    wait_ev();
    chk(ev, 4'h1);
    issue(NBP_C_PROGRAM, 23'h000040, 16'h00c3, 6'h00);
    wait_ev();
    chk(ev, 4'h8);
    chk(flash.wa.size(), 2);
    w(0, U1, NBP_CMD_PROGRAM);
    w(1, 23'h000040, 16'h00c3);
    issue(NBP_C_BUFFER, 23'h000080, '0, 6'h00);
    ld(23'h000085, 16'h1234);
    wait_ev();
    chk(ev, 4'h8);
    chk(flash.wa.size(), 4);
    w(0, 23'h000080, NBP_CMD_WRBUF);
    w(3, 23'h000085, NBP_CMD_CONFIRM);
    issue(NBP_C_RESET, '0, '0, '0);
    wait_ev();
    chk(bypass_mode, 1'b1);
    issue(NBP_C_BYPASS_OFF, '0, '0, '0);
    wait_ev();
    chk({flash.wd[0], flash.wd[1]}, {NBP_CMD_BYP_RST1, NBP_CMD_BYP_RST2});
    chk(bypass_mode, 1'b0);
  endtask
  task automatic t_buffer();
    int i;
    int off[4] = '{0, 1, 0, 3};
    issue(NBP_C_BUFFER, 23'h0000a0, '0, 6'h03);
    for (i = 0; i < 4; i++) ld(23'h0000a0 + 23'(off[i]), 16'(16'h1111 * (i + 1)));
    wait_ev();
    chk(ev, 4'h8);
    chk(flash.wa.size(), 9);
    unl(0);
    w(3, 23'h0000a0, 16'h0003);
    for (i = 0; i < 4; i++) w(4 + i, 23'h0000a0 + 23'(off[i]), 16'(16'h1111 * (i + 1)));
    w(8, 23'h0000a3, NBP_CMD_CONFIRM);
    issue(NBP_C_BUFFER, 23'h000100, '0, 6'd32);
    wait_ev();
    chk(ev, 4'h1);
    issue(NBP_C_BUFFER, 23'h000100, '0, 6'd31);
    for (i = 0; i < 32; i++) ld(23'h000100 + 23'(i), 16'h0100 + 16'(i));
    wait_ev();
    chk(ev, 4'h8);
    chk(flash.wa.size(), 37);
    issue(NBP_C_BUFFER, 23'h0000c0, '0, 6'h01);
    ld(23'h0000c0, 16'h1111);
    ld(23'h0000e0, 16'h2222);
    wait_ev();
    chk(ev, 4'h1);
    ld(23'h0000c1, 16'h3333);
    wait_ev();
    chk(ev, 4'h8);
  endtask
  task automatic t_fault();
    fault_mode <= 2'h1;
    issue(NBP_C_PROGRAM, 23'h000200, 16'h0f0e, 6'h00);
    wait_ev();
    chk(ev, 4'h4);
    fault_mode <= 2'h2;
    issue(NBP_C_RESET, '0, '0, '0);
    wait_ev();
    w(0, U1, NBP_CMD_RESET);
    issue(NBP_C_BUFFER, 23'h000300, '0, 6'h00);
    ld(23'h000301, 16'h0707);
    wait_ev();
    chk(ev, 4'h2);
    fault_mode <= 2'h0;
    issue(NBP_C_ABORT_RESET, '0, '0, '0);
    wait_ev();
    chk(flash.wa.size(), 3);
    unl(0);
    w(2, U1, NBP_CMD_RESET);
  endtask
  task automatic t_misc();
    issue(NBP_C_SUSPEND, 23'h000400, '0, '0);
    wait_ev();
    w(0, 23'h000400, NBP_CMD_SUSPEND);
    issue(NBP_C_RESUME, 23'h000400, '0, '0);
    wait_ev();
    w(0, 23'h000400, NBP_CMD_RESUME);
    vpp_high <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(bypass_mode, 1'b1);
    issue(NBP_C_PROGRAM, 23'h000500, 16'h0011, 6'h00);
    wait_ev();
    chk(flash.wa.size(), 2);
    vpp_high <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(bypass_mode, 1'b0);
    issue(NBP_C_PROGRAM, 23'h000600, 16'h00ff, 6'h00);
    repeat (3) @(posedge mclk);
    chk(ce_b, 1'b0);
    // reset lands while the write strobe is still high: no partial write
    rst_b <= 1'b0;
    @(posedge mclk);
    chk({busy, ce_b, we_b, dq_oe}, 4'h6);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(cmd_ready, 1'b1);
    chk(flash.wa.size(), 0);
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    repeat (60000) @(posedge mclk);
    bad_count++;
    stop_test();
  end
  initial begin
    {rst_b, cmd_valid, vpp_high, load_valid} = 4'h0;
    cmd = NBP_C_RESET;
    {cmd_addr, cmd_data, cmd_count, load_addr, load_data, fault_mode} = '0;
    bad_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    t_program();
    t_bypass();
    t_buffer();
    t_fault();
    t_misc();
    stop_test();
  end
endmodule // tb_top
